// ### common/cmp_timer_pkg.sv
// Constants for the eight-bit compare timer.
// Assumes one 100 MHz system clock and a plain byte register port.
package cmp_timer_pkg;
    // Register offsets
    localparam logic [2:0] ADDR_CTL = 3'h0;
    localparam logic [2:0] ADDR_STAT = 3'h1;
    localparam logic [2:0] ADDR_CONST_A = 3'h2;
    localparam logic [2:0] ADDR_CONST_B = 3'h3;
    localparam logic [2:0] ADDR_COUNT = 3'h4;
    localparam logic [2:0] ADDR_TOP = 3'h4;
    // Control register fields
    localparam int CTL_IE_B = 7;
    localparam int CTL_IE_A = 6;
    localparam int CTL_IE_WRAP = 5;
    localparam int CTL_CLR_HI = 4;
    localparam int CTL_CLR_LO = 3;
    localparam int CTL_SRC_HI = 2;
    localparam int CTL_SRC_LO = 0;
    localparam int EXT_SEL_BIT = 3;
    // Status register fields
    localparam int STAT_FLAG_B = 7;
    localparam int STAT_FLAG_A = 6;
    localparam int STAT_WRAP = 5;
    localparam int STAT_RSVD = 4;
    localparam int STAT_ACT_HI = 3;
    localparam int STAT_ACT_LO = 0;
    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [3:0] ACT_RESET = 4'h0;
    localparam logic [7:0] CONST_RESET = 8'hFF;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    // Prescaler taps: divide by 8, 64, 1024
    localparam int PRE_W = 10;
    localparam int TAP_DIV8 = 2;
    localparam int TAP_DIV64 = 5;
    localparam int TAP_DIV1024 = 9;
    // Action and clear encodings
    localparam logic [1:0] ACT_KEEP = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_MATCH_A = 2'h1;
    localparam logic [1:0] CLR_MATCH_B = 2'h2;
    localparam logic [1:0] CLR_EXT = 2'h3;
    // External edge selections
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ### rtl/cmp_timer.sv
// Eight-bit up-counter with two compare constants, output action pin and flags.
// Assumes a byte register port on the system clock; external pins are asynchronous.
// What this block does
// - One count pulse per internal source period or per selected external edge
// - External input counts rise, fall or both
// - Match asserted in last state before advance
// - Match sets flag A or flag B
// - Match drives wave_out per action field
// - Match A or B clears count if selected
// - Clear mode 11 clears on external reset rise
// - Rollover FF to 00 sets wrap_flag
// - Three irq lines: flag and enable
// - Priority A, B, wrap; wrap not transfer-served
// - Transfer service clears matching flag
// - Clear beats count write in same cycle
// - Count write beats increment
// - Constant write suppresses its match
// - Coincident actions: toggle, one, zero, none
// - Internal pulse from source falling edge
// - Source change high to low counts once
// - Stopped source is treated as low
// - Internal/external switch may count spuriously
// - Action 0110 gives pulse train
// - Clear select encoding 00/01/10/11
// - Sources: /8, /64, /1024, stopped, external edges
// - Action encoding; B high pair; output starts 0
// - Flag clears by read-one then write-zero
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module cmp_timer
    import cmp_timer_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Transfer controller service acknowledge
    input wire logic xfer_ack_a_in,
    input wire logic xfer_ack_b_in,
    // External pins
    input wire logic ext_count_in,
    input wire logic ext_reset_in,
    output logic wave_out,
    // Interrupt requests
    output logic match_irq_a,
    output logic match_irq_b,
    output logic wrap_irq
);

    logic [7:0] ctl_reg;
    logic [3:0] act_reg;
    logic [7:0] const_a_reg;
    logic [7:0] const_b_reg;
    logic [7:0] up_count_reg;
    logic [7:0] up_count_next;
    logic match_flag_a_reg;
    logic match_flag_b_reg;
    logic wrap_flag_reg;
    logic [2:0] seen_reg;
    logic [PRE_W-1:0] pre_reg;
    logic [2:0] cnt_sync_reg;
    logic [2:0] rst_sync_reg;
    logic src_level_reg;
    logic src_level;
    logic count_pulse;
    logic ext_rise;
    logic ext_fall;
    logic ext_clr_rise;
    logic match_a;
    logic match_b;
    logic clear_hit;
    logic wr_count;
    logic wr_ctl;
    logic wr_stat;
    logic [1:0] clr_sel;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] act_win;
    logic is_ext;

    assign wr_ctl = reg_wr_in && reg_addr_in == ADDR_CTL;
    assign wr_stat = reg_wr_in && reg_addr_in == ADDR_STAT;
    assign wr_count = reg_wr_in && reg_addr_in == ADDR_COUNT;
    assign clr_sel = ctl_reg[CTL_CLR_HI:CTL_CLR_LO];
    assign is_ext = ctl_reg[EXT_SEL_BIT];
    assign act_a = act_reg[1:0];
    assign act_b = act_reg[STAT_ACT_HI:STAT_ACT_HI-1];

    // Prescaler
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    // Synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            cnt_sync_reg <= 3'h0;
            rst_sync_reg <= 3'h0;
        end else begin
            cnt_sync_reg <= {cnt_sync_reg[1:0], ext_count_in};
            rst_sync_reg <= {rst_sync_reg[1:0], ext_reset_in};
        end
    end

    assign ext_rise = cnt_sync_reg[1] && !cnt_sync_reg[2];
    assign ext_fall = !cnt_sync_reg[1] && cnt_sync_reg[2];
    assign ext_clr_rise = rst_sync_reg[1] && !rst_sync_reg[2];

    // Selected internal source level; stopped and external count as low
    always_comb begin
        src_level = 1'b0;
        if (!is_ext) begin
            case (ctl_reg[1:0])
                2'h1: src_level = pre_reg[TAP_DIV8];
                2'h2: src_level = pre_reg[TAP_DIV64];
                2'h3: src_level = pre_reg[TAP_DIV1024];
                default: src_level = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            src_level_reg <= 1'b0;
        end else begin
            src_level_reg <= src_level;
        end
    end

    // Count pulse: internal falling edge, or chosen external edge
    always_comb begin
        count_pulse = src_level_reg && !src_level;
        if (is_ext) begin
            case (ctl_reg[1:0])
                EDGE_RISE: count_pulse = ext_rise;
                EDGE_FALL: count_pulse = ext_fall;
                EDGE_BOTH: count_pulse = ext_rise || ext_fall;
                default: count_pulse = 1'b0;
            endcase
        end
    end

    // Match in the last state before advance; constant write masks it
    assign match_a = count_pulse && up_count_reg == const_a_reg
        && !(reg_wr_in && reg_addr_in == ADDR_CONST_A);
    assign match_b = count_pulse && up_count_reg == const_b_reg
        && !(reg_wr_in && reg_addr_in == ADDR_CONST_B);

    assign clear_hit = (clr_sel == CLR_MATCH_A && match_a) || (clr_sel == CLR_MATCH_B && match_b)
        || (clr_sel == CLR_EXT && ext_clr_rise);

    always_comb begin
        up_count_next = up_count_reg;
        if (clear_hit) begin
            up_count_next = COUNT_RESET;
        end else if (wr_count) begin
            up_count_next = reg_wdata_in;
        end else if (count_pulse) begin
            up_count_next = up_count_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            up_count_reg <= COUNT_RESET;
        end else begin
            up_count_reg <= up_count_next;
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            ctl_reg <= CTL_RESET;
            act_reg <= ACT_RESET;
            const_a_reg <= CONST_RESET;
            const_b_reg <= CONST_RESET;
        end else begin
            if (wr_ctl) begin
                ctl_reg <= reg_wdata_in;
            end
            if (wr_stat) begin
                act_reg <= reg_wdata_in[STAT_ACT_HI:STAT_ACT_LO];
            end
            if (reg_wr_in && reg_addr_in == ADDR_CONST_A) begin
                const_a_reg <= reg_wdata_in;
            end
            if (reg_wr_in && reg_addr_in == ADDR_CONST_B) begin
                const_b_reg <= reg_wdata_in;
            end
        end
    end

    // Flags seen as one by a status read may be cleared by writing zero
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            seen_reg <= 3'h0;
        end else if (reg_rd_in && reg_addr_in == ADDR_STAT) begin
            seen_reg <= {match_flag_b_reg, match_flag_a_reg, wrap_flag_reg};
        end else if (wr_stat) begin
            seen_reg <= 3'h0;
        end
    end

    // Status flags; a set wins over any clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            match_flag_a_reg <= 1'b0;
            match_flag_b_reg <= 1'b0;
            wrap_flag_reg <= 1'b0;
        end else begin
            if (match_a) begin
                match_flag_a_reg <= 1'b1;
            end else if (xfer_ack_a_in) begin
                match_flag_a_reg <= 1'b0;
            end else if (wr_stat && seen_reg[1] && !reg_wdata_in[STAT_FLAG_A]) begin
                match_flag_a_reg <= 1'b0;
            end
            if (match_b) begin
                match_flag_b_reg <= 1'b1;
            end else if (xfer_ack_b_in) begin
                match_flag_b_reg <= 1'b0;
            end else if (wr_stat && seen_reg[2] && !reg_wdata_in[STAT_FLAG_B]) begin
                match_flag_b_reg <= 1'b0;
            end
            if (up_count_reg == COUNT_MAX && up_count_next == COUNT_RESET && count_pulse && !wr_count) begin
                wrap_flag_reg <= 1'b1;
            end else if (wr_stat && seen_reg[0] && !reg_wdata_in[STAT_WRAP]) begin
                wrap_flag_reg <= 1'b0;
            end
        end
    end

    // Output action resolution by priority
    always_comb begin
        act_win = ACT_KEEP;
        if (match_a && match_b) begin
            act_win = (act_a > act_b) ? act_a : act_b;
        end else if (match_a) begin
            act_win = act_a;
        end else if (match_b) begin
            act_win = act_b;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            wave_out <= 1'b0;
        end else begin
            case (act_win)
                ACT_LOW: wave_out <= 1'b0;
                ACT_HIGH: wave_out <= 1'b1;
                ACT_TOGGLE: wave_out <= !wave_out;
                default: wave_out <= wave_out;
            endcase
        end
    end

    // Interrupt requests; the controller ranks them
    assign match_irq_a = match_flag_a_reg && ctl_reg[CTL_IE_A];
    assign match_irq_b = match_flag_b_reg && ctl_reg[CTL_IE_B];
    assign wrap_irq = wrap_flag_reg && ctl_reg[CTL_IE_WRAP];

    // Read data one cycle after the strobe
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_CTL: reg_rdata_out <= ctl_reg;
                ADDR_STAT: reg_rdata_out <= {match_flag_b_reg, match_flag_a_reg, wrap_flag_reg,
                    1'b1, act_reg};
                ADDR_CONST_A: reg_rdata_out <= const_a_reg;
                ADDR_CONST_B: reg_rdata_out <= const_b_reg;
                ADDR_COUNT: reg_rdata_out <= up_count_reg;
                default: reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // Checks
    property p_match_flag_a;
        @(posedge core_clk_in) disable iff (!reset_n_in) match_a |=> match_flag_a_reg;
    endproperty
    a_match_flag_a: assert property (p_match_flag_a) else $error("flag A not set");

    property p_clear_wins;
        @(posedge core_clk_in) disable iff (!reset_n_in) clear_hit |=> up_count_reg == 8'h00;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("count not cleared");

    property p_write_wins;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (wr_count && !clear_hit) |=> up_count_reg == $past(reg_wdata_in);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("write lost");

    property p_irq_a;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            match_irq_a == (match_flag_a_reg && ctl_reg[CTL_IE_A]);
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("irq A wrong");

    property p_wrap;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (up_count_reg == 8'hFF && count_pulse && !wr_count && !clear_hit) |=> wrap_flag_reg;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap not flagged");

    property p_toggle;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (act_win == ACT_TOGGLE) |=> wave_out != $past(wave_out);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_step;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (count_pulse && !wr_count && !clear_hit) |=> up_count_reg == $past(up_count_reg) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count did not step");

    property p_ack_clear;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (xfer_ack_b_in && !match_b) |=> !match_flag_b_reg;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("flag B kept");

    property p_ack_clear_a;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (xfer_ack_a_in && !match_a) |=> !match_flag_a_reg;
    endproperty
    a_ack_clear_a: assert property (p_ack_clear_a) else $error("flag A kept");

    property p_const_mask;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (count_pulse && up_count_reg == const_a_reg && reg_wr_in && reg_addr_in == ADDR_CONST_A
                && !match_flag_a_reg) |=> !match_flag_a_reg;
    endproperty
    a_const_mask: assert property (p_const_mask) else $error("masked match set flag");

    property p_write_one;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (wr_stat && reg_wdata_in[STAT_WRAP] && wrap_flag_reg) |=> wrap_flag_reg;
    endproperty
    a_write_one: assert property (p_write_one) else $error("writing one cleared flag");

    property p_drive_high;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (match_a && !match_b && act_a == ACT_HIGH) |=> wave_out;
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("output not driven high");

    property p_coincide;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            (match_a && match_b && (act_a == ACT_TOGGLE || act_b == ACT_TOGGLE))
                |=> wave_out != $past(wave_out);
    endproperty
    a_coincide: assert property (p_coincide) else $error("toggle lost priority");

    sequence s_src_high;
        !is_ext && src_level;
    endsequence

    sequence s_src_fall;
        !is_ext && !src_level && !wr_count && !clear_hit;
    endsequence

    property p_src_fall;
        @(posedge core_clk_in) disable iff (!reset_n_in)
            s_src_high ##1 s_src_fall |=> up_count_reg == $past(up_count_reg) + 8'h01;
    endproperty
    a_src_fall: assert property (p_src_fall) else $error("internal fall not counted");

endmodule

// ### tb/cmp_timer_test.sv
// Self-checking bench for the compare timer.
// Assumes the design drives its pins from one 100 MHz clock.
`timescale 1ns/1ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module cmp_timer_test;
    import cmp_timer_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic ext_count_in = 1'b0;
    logic ext_reset_in = 1'b0;
    logic serve_en = 1'b0;
    logic [7:0] reg_rdata_out;
    logic xfer_ack_a, xfer_ack_b, wave_out, match_irq_a, match_irq_b, wrap_irq;
    int err_count = 0;
    int tests_run = 0;
    logic [7:0] rv;
    logic w0;

    cmp_timer uut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .xfer_ack_a_in(xfer_ack_a), .xfer_ack_b_in(xfer_ack_b),
        .ext_count_in(ext_count_in), .ext_reset_in(ext_reset_in), .wave_out(wave_out),
        .match_irq_a(match_irq_a), .match_irq_b(match_irq_b), .wrap_irq(wrap_irq));
    xfer_ctrl_model xfer (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .serve_en_in(serve_en),
        .match_irq_a_in(match_irq_a), .match_irq_b_in(match_irq_b),
        .ack_a_out(xfer_ack_a), .ack_b_out(xfer_ack_b));

    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end

    task stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask

    task ext_pulse();
        repeat (4) @(posedge core_clk_in);
        ext_count_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        ext_count_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
    endtask

    // Reset values and an unmapped index
    task t_reset();
        logic [7:0] exp [6];
        exp = '{8'h00, 8'h10, 8'hFF, 8'hFF, 8'h00, 8'h00};
        `CHECK({wave_out, match_irq_a, match_irq_b, wrap_irq}, 4'h0)
        for (int i = 0; i < 6; i++) begin
            rd(3'(i), rv);
            `CHECK(rv, exp[i])
        end
    endtask

    // Rising external edges, clear on match A, pulse output 0110
    task t_pulse();
        wr(ADDR_CONST_A, 8'h03);
        wr(ADDR_CONST_B, 8'h01);
        wr(ADDR_STAT, 8'h06);
        wr(ADDR_CTL, 8'h49);
        wr(ADDR_COUNT, 8'h00);
        repeat (3) ext_pulse();
        rd(ADDR_COUNT, rv);
        `CHECK(rv, 8'h03)
        ext_pulse();
        rd(ADDR_COUNT, rv);
        `CHECK(rv, 8'h00)
        `CHECK(wave_out, 1'b1)
        `CHECK({match_irq_a, match_irq_b}, 2'b10)
        rd(ADDR_STAT, rv);
        `CHECK(rv, 8'hD6)
        repeat (2) ext_pulse();
        `CHECK(wave_out, 1'b0)
        rd(ADDR_COUNT, rv);
        `CHECK(rv, 8'h02)
    endtask

    // Transfer service clears flag A, then flag B once its interrupt enable is set
    task t_service();
        int i;
        serve_en <= 1'b1;
        for (i = 0; i < 50 && match_irq_a !== 1'b0; i++) begin
            @(posedge core_clk_in);
        end
        if (i == 50) begin
            err_count++;
            stop_test();
        end
        rd(ADDR_STAT, rv);
        `CHECK(rv, 8'h96)
        wr(ADDR_CTL, 8'hC9);
        repeat (2) @(posedge core_clk_in);
        for (i = 0; i < 50 && match_irq_b !== 1'b0; i++) begin
            @(posedge core_clk_in);
        end
        if (i == 50) begin
            err_count++;
            stop_test();
        end
        serve_en <= 1'b0;
        rd(ADDR_STAT, rv);
        `CHECK(rv, 8'h16)
    endtask

    // Each external edge mode, then external clear
    task t_edges();
        logic [1:0] mode [3];
        logic [7:0] exp [3];
        mode = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
        exp = '{8'h02, 8'h02, 8'h04};
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTL, {6'h06, mode[i]});
            wr(ADDR_COUNT, 8'h00);
            repeat (2) ext_pulse();
            rd(ADDR_COUNT, rv);
            `CHECK(rv, exp[i])
        end
        ext_reset_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        ext_reset_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        rd(ADDR_COUNT, rv);
        `CHECK(rv, 8'h00)
    endtask

    // Coincident matches: toggle on A beats drive 0 on B
    task t_coincide();
        wr(ADDR_CONST_A, 8'h02);
        wr(ADDR_CONST_B, 8'h02);
        wr(ADDR_STAT, 8'h07);
        wr(ADDR_CTL, 8'h19);
        wr(ADDR_COUNT, 8'h00);
        w0 = wave_out;
        repeat (3) ext_pulse();
        `CHECK(wave_out, ~w0)
    endtask

    // Internal divide by 8, rollover, flag clearing
    task t_wrap();
        wr(ADDR_CTL, 8'h21);
        wr(ADDR_COUNT, 8'hFE);
        repeat (40) @(posedge core_clk_in);
        `CHECK(wrap_irq, 1'b1)
        wr(ADDR_CTL, 8'h20);
        wr(ADDR_STAT, 8'hE7);
        rd(ADDR_STAT, rv);
        `CHECK(rv[STAT_WRAP], 1'b1)
        wr(ADDR_STAT, 8'h07);
        rd(ADDR_STAT, rv);
        `CHECK(rv, 8'h17)
        `CHECK(wrap_irq, 1'b0)
    endtask

    initial begin
        #200000;
        err_count++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        t_reset();
        t_pulse();
        t_service();
        t_edges();
        t_coincide();
        t_wrap();
        stop_test();
    end
endmodule

// ### tb/xfer_ctrl_model.sv
// Transfer controller model that serves the two match requests.
// Assumes the timer's request lines and a bench enable on the system clock.
`timescale 1ns/1ps

module xfer_ctrl_model (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Control from bench
    input wire logic serve_en_in,
    // Requests from timer
    input wire logic match_irq_a_in,
    input wire logic match_irq_b_in,
    // Service pulses
    output logic ack_a_out,
    output logic ack_b_out
);
    logic busy;
    assign busy = ack_a_out | ack_b_out;
    // Request A first, B next; the wrap request is never served
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            ack_a_out <= 1'b0;
            ack_b_out <= 1'b0;
        end else begin
            ack_a_out <= serve_en_in & match_irq_a_in & ~busy;
            ack_b_out <= serve_en_in & match_irq_b_in & ~match_irq_a_in & ~busy;
        end
    end
endmodule
